// ### rtl/gee_pkg.sv
// gee_pkg: register map, codes and carriers for the guest entry and
// exception reflect block.
// assumes: one 200 MHz clock, AHB-Lite register access.
package gee_pkg;
    // byte offsets of the register words
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_OPLO = 8'h04;
    localparam logic [7:0] A_OPHI = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_WKLO = 8'h10;
    localparam logic [7:0] A_WKHI = 8'h14;
    localparam logic [7:0] A_CTLO = 8'h18;
    localparam logic [7:0] A_CTHI = 8'h1C;
    localparam logic [7:0] A_PALO = 8'h20;
    localparam logic [7:0] A_PAHI = 8'h24;
    localparam logic [7:0] A_IERR = 8'h28;
    localparam logic [7:0] A_CTRL = 8'h2C;
    localparam logic [7:0] A_EINF = 8'h30;
    localparam logic [7:0] A_EERR = 8'h34;
    localparam logic [7:0] A_BMAP = 8'h38;
    localparam logic [7:0] A_PFMM = 8'h3C;
    localparam logic [7:0] A_GEXC = 8'h40;
    localparam logic [7:0] A_FADR = 8'h44;
    localparam logic [7:0] A_XRSN = 8'h48;
    localparam logic [7:0] A_XINF = 8'h4C;
    localparam logic [7:0] A_XERR = 8'h50;
    localparam logic [7:0] A_XQUL = 8'h54;
    localparam logic [7:0] A_VINF = 8'h58;
    localparam logic [7:0] A_ROUT = 8'h5C;
    localparam logic [7:0] A_RINF = 8'h60;
    localparam logic [7:0] A_RERR = 8'h64;
    localparam logic [7:0] A_CFG = 8'h68;
    // operation codes written to the command word
    localparam logic [2:0] OP_CLEAR = 3'h1;
    localparam logic [2:0] OP_LOAD = 3'h2;
    localparam logic [2:0] OP_FIRST = 3'h3;
    localparam logic [2:0] OP_RESUME = 3'h4;
    // instruction-error codes
    localparam logic [7:0] ERR_CLEAR = 8'h02;
    localparam logic [7:0] ERR_NOTCLR = 8'h04;
    localparam logic [7:0] ERR_NOTLCH = 8'h05;
    localparam logic [7:0] ERR_CTRL = 8'h07;
    localparam logic [7:0] ERR_LOAD = 8'h09;
    // exit reasons
    localparam logic [31:0] RSN_EXC = 32'h0000_0000;
    localparam logic [31:0] RSN_BADGST = 32'h8000_0021;
    // capability: bits that must be 1, bits that may be 1
    localparam logic [31:0] CAP_ALLOW0 = 32'h0000_0016;
    localparam logic [31:0] CAP_ALLOW1 = 32'h0FFF_FFFF;
    localparam logic [63:0] PTR_NONE = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [2:0] TYPE_HWEXC = 3'h3;
    localparam logic [7:0] VEC_DF = 8'h08;
    localparam logic [7:0] VEC_PF = 8'h0E;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    typedef enum logic [1:0] {
        ST_HOST = 2'b01,
        ST_GUEST = 2'b10
    } gee_state_t;

    typedef enum logic [1:0] {
        OUT_NONE = 2'h0,
        OUT_REDELIVER = 2'h1,
        OUT_DOUBLE = 2'h2,
        OUT_TRIPLE = 2'h3
    } gee_out_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
    } gee_aphase_t;

    typedef struct packed {
        logic [31:0] reason;
        logic [31:0] info;
        logic [31:0] errc;
        logic [31:0] qual;
    } gee_exit_t;

    function automatic logic gee_benign(input logic [7:0] v);
        return (v >= 8'h01 && v <= 8'h07) || v == 8'h09 ||
            (v >= 8'h10 && v <= 8'h13);
    endfunction : gee_benign

    function automatic logic gee_contrib(input logic [7:0] v);
        return v == 8'h00 || (v >= 8'h0A && v <= 8'h0D);
    endfunction : gee_contrib
endpackage : gee_pkg

// ### rtl/gee_top.sv
// gee_top: guest control-structure tracking and exception reflect
// decision, as a word-wide AHB-Lite slave.
// assumes: single master, word transfers only, hready from this slave.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Function
// RQ1 - clear resets launch state and sets working pointer to all ones
// RQ2 - successful clear leaves carry and zero flags at zero
// RQ3 - pointer load puts the supplied address in the working pointer
// RQ4 - monitor aligns region to 4 KB and writes revision id
// RQ5 - entry fails when controls break allowed-0 or allowed-1 settings
// RQ6 - monitor gives host task selector with zero indicator and privilege
// RQ7 - early entry failure sets a flag and records an error code; with no working pointer the code sets only carry and records no code
// RQ8 - bad guest state loads host state as though exiting
// RQ9 - first entry copies working to controlling, old one to parent
// RQ10 - successful first entry marks the structure launched
// RQ11 - monitor uses resume entry for launched structures
// RQ12 - exception exits when its bitmap bit is set; page faults check code
// RQ13 - monitor copies exit info and error code to entry fields
// RQ14 - entry info bits 30:12 must be zero or entry fails
// RQ15 - vectoring bit 31 set when exception hit during event delivery
// RQ16 - vectors split into benign, contributory and page fault
// RQ17 - listed cases re-deliver the original exception
// RQ18 - hardware-exception nesting cases yield a double fault
// RQ19 - double fault injected as vector 8, type 3, code zero
// RQ20 - vectoring double fault means triple fault, inject nothing
// RQ21 - page-fault exit qualification holds faulting linear address
// RQ22 - triple checked first, then double, then re-delivery
// RQ23 - without vectoring bit 31 the exit exception is re-delivered
module gee_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic in_guest
);
    ////////////////////////////////////////////////////////////////////
    gee_pkg::gee_aphase_t aph_reg, aph_next;
    logic rdw_reg, rdw_next;
    logic [31:0] hrdata_reg, hrdata_next;
    gee_pkg::gee_state_t st_reg, st_next;
    logic [63:0] op_reg, op_next, wk_reg, wk_next;
    logic [63:0] ct_reg, ct_next, pa_reg, pa_next;
    logic [7:0] lch_reg, lch_next, ierr_reg, ierr_next;
    logic cf_reg, cf_next, zf_reg, zf_next;
    logic hld_reg, hld_next, dlv_reg, dlv_next, bad_reg, bad_next;
    logic [31:0] ctrl_reg, ctrl_next, einf_reg, einf_next;
    logic [31:0] eerr_reg, eerr_next, bmap_reg, bmap_next;
    logic [31:0] pfmm_reg, pfmm_next, fadr_reg, fadr_next;
    logic [31:0] vinf_reg, vinf_next;
    gee_pkg::gee_exit_t ex_reg, ex_next;
    gee_pkg::gee_out_t out_reg, out_next;
    logic [31:0] rinf_reg, rinf_next, rerr_reg, rerr_next;

    logic wr_go, cmd_go, exc_go, ptr_ok, aligned, ctrl_bad, fail;
    logic [7:0] fcode, xv, vv;
    logic [2:0] op;
    logic [2:0] idx;

    assign hreadyout = ~rdw_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign in_guest = st_reg == gee_pkg::ST_GUEST;

    ////////////////////////////////////////////////////////////////////
    // bus: writes take no wait, reads one wait state so that a read
    // right behind a write or command sees its effect, except the reflect words (A_ROUT, A_RINF, A_RERR), which lag one more cycle
    always_comb begin
        aph_next.rd = 1'b0;
        aph_next.wr = 1'b0;
        aph_next.addr = aph_reg.addr;
        if (hsel && hready && htrans[1] &&
            hsize == gee_pkg::HSIZE_WORD) begin
            aph_next.rd = ~hwrite;
            aph_next.wr = hwrite;
            aph_next.addr = haddr[7:0];
        end
        // wait raised at the address edge, so hrdata is loaded on the same
        // edge at which hreadyout returns high
        rdw_next = aph_next.rd;
        hrdata_next = hrdata_reg;
        if (aph_reg.rd) begin
            case (aph_reg.addr)
                gee_pkg::A_OPLO: hrdata_next = op_reg[31:0];
                gee_pkg::A_OPHI: hrdata_next = op_reg[63:32];
                gee_pkg::A_STAT: hrdata_next = {26'h0, hld_reg,
                    dlv_reg, lch_reg[idx], in_guest, zf_reg, cf_reg};
                gee_pkg::A_WKLO: hrdata_next = wk_reg[31:0];
                gee_pkg::A_WKHI: hrdata_next = wk_reg[63:32];
                gee_pkg::A_CTLO: hrdata_next = ct_reg[31:0];
                gee_pkg::A_CTHI: hrdata_next = ct_reg[63:32];
                gee_pkg::A_PALO: hrdata_next = pa_reg[31:0];
                gee_pkg::A_PAHI: hrdata_next = pa_reg[63:32];
                gee_pkg::A_IERR: hrdata_next = {24'h0, ierr_reg};
                gee_pkg::A_CTRL: hrdata_next = ctrl_reg;
                gee_pkg::A_EINF: hrdata_next = einf_reg;
                gee_pkg::A_EERR: hrdata_next = eerr_reg;
                gee_pkg::A_BMAP: hrdata_next = bmap_reg;
                gee_pkg::A_PFMM: hrdata_next = pfmm_reg;
                gee_pkg::A_FADR: hrdata_next = fadr_reg;
                gee_pkg::A_XRSN: hrdata_next = ex_reg.reason;
                gee_pkg::A_XINF: hrdata_next = ex_reg.info;
                gee_pkg::A_XERR: hrdata_next = ex_reg.errc;
                gee_pkg::A_XQUL: hrdata_next = ex_reg.qual;
                gee_pkg::A_VINF: hrdata_next = vinf_reg;
                gee_pkg::A_ROUT: hrdata_next = {30'h0, out_reg};
                gee_pkg::A_RINF: hrdata_next = rinf_reg;
                gee_pkg::A_RERR: hrdata_next = rerr_reg;
                gee_pkg::A_CFG: hrdata_next = {31'h0, bad_reg};
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_reg <= '0;
            rdw_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            aph_reg <= aph_next;
            rdw_reg <= rdw_next;
            hrdata_reg <= hrdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign wr_go = aph_reg.wr;
    assign op = hwdata[2:0];
    assign cmd_go = wr_go && aph_reg.addr == gee_pkg::A_CMD &&
        st_reg == gee_pkg::ST_HOST;
    assign exc_go = wr_go && aph_reg.addr == gee_pkg::A_GEXC &&
        st_reg == gee_pkg::ST_GUEST;
    assign ptr_ok = wk_reg != gee_pkg::PTR_NONE;
    assign aligned = op_reg[11:0] == 12'h000;
    assign idx = wk_reg[14:12];
    // RQ5 capability check
    assign ctrl_bad = |((ctrl_reg & ~gee_pkg::CAP_ALLOW1) |
        (~ctrl_reg & gee_pkg::CAP_ALLOW0));
    assign xv = ex_reg.info[7:0];
    assign vv = vinf_reg[7:0];

    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        wk_next = wk_reg;
        ct_next = ct_reg;
        pa_next = pa_reg;
        lch_next = lch_reg;
        ierr_next = ierr_reg;
        cf_next = cf_reg;
        zf_next = zf_reg;
        hld_next = hld_reg;
        dlv_next = dlv_reg;
        bad_next = bad_reg;
        ctrl_next = ctrl_reg;
        einf_next = einf_reg;
        eerr_next = eerr_reg;
        bmap_next = bmap_reg;
        pfmm_next = pfmm_reg;
        fadr_next = fadr_reg;
        vinf_next = vinf_reg;
        ex_next = ex_reg;
        fail = 1'b0;
        fcode = 8'h00;
        if (wr_go) begin
            case (aph_reg.addr)
                gee_pkg::A_OPLO: op_next[31:0] = hwdata;
                gee_pkg::A_OPHI: op_next[63:32] = hwdata;
                gee_pkg::A_CTRL: ctrl_next = hwdata;
                gee_pkg::A_EINF: einf_next = hwdata;
                gee_pkg::A_EERR: eerr_next = hwdata;
                gee_pkg::A_BMAP: bmap_next = hwdata;
                gee_pkg::A_PFMM: pfmm_next = hwdata;
                gee_pkg::A_FADR: fadr_next = hwdata;
                gee_pkg::A_CFG: bad_next = hwdata[0];
                default: ;
            endcase
        end
        if (cmd_go) begin
            cf_next = 1'b0;
            zf_next = 1'b0;
            hld_next = 1'b0;
            case (op)
                gee_pkg::OP_CLEAR: begin
                    if (!aligned) begin
                        fail = 1'b1;
                        fcode = gee_pkg::ERR_CLEAR;
                    end else begin
                        // RQ1 clear and invalidate
                        lch_next[op_reg[14:12]] = 1'b0;
                        wk_next = gee_pkg::PTR_NONE;
                    end
                end
                gee_pkg::OP_LOAD: begin
                    if (!aligned) begin
                        fail = 1'b1;
                        fcode = gee_pkg::ERR_LOAD;
                    end else begin
                        // RQ3 load working pointer
                        wk_next = op_reg;
                    end
                end
                gee_pkg::OP_FIRST, gee_pkg::OP_RESUME: begin
                    // RQ7 early checks flag a failure
                    if (!ptr_ok) begin
                        fail = 1'b1;
                    end else if (op == gee_pkg::OP_FIRST && lch_reg[idx]) begin
                        fail = 1'b1;
                        fcode = gee_pkg::ERR_NOTCLR;
                    end else if (op == gee_pkg::OP_RESUME && !lch_reg[idx]) begin
                        fail = 1'b1;
                        fcode = gee_pkg::ERR_NOTLCH;
                    end else if (ctrl_bad || |einf_reg[30:12]) begin
                        // RQ14 reserved entry bits refused
                        fail = 1'b1;
                        fcode = gee_pkg::ERR_CTRL;
                    end else if (bad_reg) begin
                        // RQ8 back to host as on an exit
                        hld_next = 1'b1;
                        ex_next.reason = gee_pkg::RSN_BADGST;
                    end else begin
                        st_next = gee_pkg::ST_GUEST;
                        dlv_next = einf_reg[31];
                        if (op == gee_pkg::OP_FIRST) begin
                            // RQ9 pointer hand-over
                            ct_next = wk_reg;
                            pa_next = ct_reg;
                            // RQ10 mark launched
                            lch_next[idx] = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
            // RQ2 flags stay zero unless failed
            if (fail && ptr_ok) begin
                zf_next = 1'b1;
                ierr_next = fcode;
            end else if (fail) begin
                cf_next = 1'b1;
            end
        end
        if (exc_go) begin
            dlv_next = 1'b0;
            // RQ12 bitmap decides; page faults also use the code match
            if (hwdata[7:0] == gee_pkg::VEC_PF ? bmap_reg[14] ==
                ((hwdata[31:16] & pfmm_reg[15:0]) == pfmm_reg[31:16]) :
                hwdata[7:5] == 3'h0 && bmap_reg[hwdata[4:0]]) begin
                st_next = gee_pkg::ST_HOST;
                ex_next.reason = gee_pkg::RSN_EXC;
                ex_next.info = {1'b1, 19'h0, hwdata[11],
                    gee_pkg::TYPE_HWEXC, hwdata[7:0]};
                ex_next.errc = hwdata[11] ? {16'h0, hwdata[31:16]} : '0;
                // RQ21 faulting address on page faults
                ex_next.qual = hwdata[7:0] == gee_pkg::VEC_PF ?
                    fadr_reg : 32'h0000_0000;
                // RQ15 nested delivery marked valid
                vinf_next = dlv_reg ? {1'b1, einf_reg[30:0]} : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reflect decision, recomputed from the latest exit record
    always_comb begin
        out_next = gee_pkg::OUT_NONE;
        rinf_next = 32'h0000_0000;
        rerr_next = 32'h0000_0000;
        if (ex_reg.info[31]) begin
            out_next = gee_pkg::OUT_REDELIVER;
            rinf_next = {1'b1, 19'h0, ex_reg.info[11:0]};
            rerr_next = ex_reg.info[11] ? ex_reg.errc : 32'h0000_0000;
            // RQ23 plain exit, no nesting
            if (!vinf_reg[31]) begin
                out_next = gee_pkg::OUT_REDELIVER;
            // RQ22 triple first
            end else if (vinf_reg[10:8] == gee_pkg::TYPE_HWEXC &&
                vv == gee_pkg::VEC_DF) begin
                // RQ20 nothing injected
                out_next = gee_pkg::OUT_TRIPLE;
                rinf_next = 32'h0000_0000;
                rerr_next = 32'h0000_0000;
            end else if (vinf_reg[10:8] == gee_pkg::TYPE_HWEXC &&
                // RQ16 vector classes
                // RQ18 double-fault cases
                ((gee_pkg::gee_contrib(vv) && gee_pkg::gee_contrib(xv)) ||
                (vv == gee_pkg::VEC_PF && (gee_pkg::gee_contrib(xv) ||
                xv == gee_pkg::VEC_PF)))) begin
                // RQ19 double-fault encoding
                out_next = gee_pkg::OUT_DOUBLE;
                rinf_next = {1'b1, 19'h0, 1'b1, gee_pkg::TYPE_HWEXC,
                    gee_pkg::VEC_DF};
                rerr_next = 32'h0000_0000;
            end
            // RQ17 remaining cases re-deliver
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= gee_pkg::ST_HOST;
            op_reg <= '0;
            wk_reg <= gee_pkg::PTR_NONE;
            ct_reg <= gee_pkg::PTR_NONE;
            pa_reg <= gee_pkg::PTR_NONE;
            lch_reg <= 8'h00;
            ierr_reg <= 8'h00;
            cf_reg <= 1'b0;
            zf_reg <= 1'b0;
            hld_reg <= 1'b0;
            dlv_reg <= 1'b0;
            bad_reg <= 1'b0;
            ctrl_reg <= gee_pkg::CAP_ALLOW0;
            einf_reg <= 32'h0000_0000;
            eerr_reg <= 32'h0000_0000;
            bmap_reg <= 32'h0000_0000;
            pfmm_reg <= 32'h0000_0000;
            fadr_reg <= 32'h0000_0000;
            vinf_reg <= 32'h0000_0000;
            ex_reg <= '0;
            out_reg <= gee_pkg::OUT_NONE;
            rinf_reg <= 32'h0000_0000;
            rerr_reg <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            wk_reg <= wk_next;
            ct_reg <= ct_next;
            pa_reg <= pa_next;
            lch_reg <= lch_next;
            ierr_reg <= ierr_next;
            cf_reg <= cf_next;
            zf_reg <= zf_next;
            hld_reg <= hld_next;
            dlv_reg <= dlv_next;
            bad_reg <= bad_next;
            ctrl_reg <= ctrl_next;
            einf_reg <= einf_next;
            eerr_reg <= eerr_next;
            bmap_reg <= bmap_next;
            pfmm_reg <= pfmm_next;
            fadr_reg <= fadr_next;
            vinf_reg <= vinf_next;
            ex_reg <= ex_next;
            out_reg <= out_next;
            rinf_reg <= rinf_next;
            rerr_reg <= rerr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_entry;
        cmd_go && (op == gee_pkg::OP_FIRST || op == gee_pkg::OP_RESUME) &&
            ptr_ok;
    endsequence
    sequence s_first_ok;
        cmd_go && op == gee_pkg::OP_FIRST && ptr_ok && !lch_reg[idx] &&
            !ctrl_bad && !(|einf_reg[30:12]) && !bad_reg;
    endsequence

    property p_clear;
        cmd_go && op == gee_pkg::OP_CLEAR && aligned |=>
            wk_reg == gee_pkg::PTR_NONE && !cf_reg && !zf_reg &&
            !lch_reg[$past(op_reg[14:12])];
    endproperty
    a_clear: assert property (p_clear) else $error("clear result wrong"); // RQ1

    property p_load;
        cmd_go && op == gee_pkg::OP_LOAD && aligned |=>
            wk_reg == $past(op_reg) && !cf_reg && !zf_reg;
    endproperty
    a_load: assert property (p_load) else $error("load result wrong"); // RQ3

    property p_ctrl;
        s_entry ##0 (ctrl_bad && !(op == gee_pkg::OP_FIRST &&
            lch_reg[idx]) && !(op == gee_pkg::OP_RESUME &&
            !lch_reg[idx])) |=> zf_reg && ierr_reg == gee_pkg::ERR_CTRL &&
            !in_guest;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("bad controls entered"); // RQ5

    property p_nowork;
        cmd_go && op == gee_pkg::OP_RESUME && !ptr_ok |=>
            cf_reg && !zf_reg && !in_guest;
    endproperty
    a_nowork: assert property (p_nowork) else $error("no carry flag"); // RQ7

    property p_badgst;
        s_first_ok or (s_entry ##0 bad_reg && !ctrl_bad &&
            !(|einf_reg[30:12]) && !lch_reg[idx] &&
            op == gee_pkg::OP_FIRST) |=> in_guest != hld_reg;
    endproperty
    a_badgst: assert property (p_badgst) else $error("bad guest loaded"); // RQ8

    property p_first;
        s_first_ok |=> ct_reg == $past(wk_reg) && pa_reg == $past(ct_reg)
            && lch_reg[idx] && in_guest;
    endproperty
    a_first: assert property (p_first) else $error("first entry wrong"); // RQ9

    property p_resv;
        s_entry ##0 (|einf_reg[30:12]) |=> !in_guest ##1 !in_guest;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits entered"); // RQ14

    property p_exit;
        exc_go && hwdata[7:0] != gee_pkg::VEC_PF && hwdata[7:5] == 3'h0 &&
            bmap_reg[hwdata[4:0]] |=> !in_guest &&
            xv == $past(hwdata[7:0]) && vinf_reg[31] == $past(dlv_reg);
    endproperty
    a_exit: assert property (p_exit) else $error("exception not exited"); // RQ12

    property p_plain;
        $rose(ex_reg.info[31]) && !vinf_reg[31] |=>
            out_reg == gee_pkg::OUT_REDELIVER && rinf_reg[30:12] == '0;
    endproperty
    a_plain: assert property (p_plain) else $error("plain exit misjudged"); // RQ23

    property p_triple;
        ex_reg.info[31] && vinf_reg[31] && vv == gee_pkg::VEC_DF &&
            vinf_reg[10:8] == gee_pkg::TYPE_HWEXC |=>
            out_reg == gee_pkg::OUT_TRIPLE && rinf_reg == '0;
    endproperty
    a_triple: assert property (p_triple) else $error("triple missed"); // RQ20
endmodule : gee_top

`default_nettype wire

// ### test/gee_monitor.sv
// gee_monitor: monitor-side model issuing structure operations over the bus
// assumes: hready is the one slave's hreadyout, word transfers only
`timescale 1ns/100ps
`default_nettype none
module gee_monitor (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = gee_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // one single transfer; waits on hready with no assumed latency
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        // read phase drives junk so a stale word is never mistaken for data
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
endmodule : gee_monitor
`default_nettype wire

// ### test/gee_top_tb_top.sv
// gee_top_tb_top: scenario bench for structure tracking and reflect logic
// assumes: gee_monitor as bus master, assertions live in the design files, register reads are checked here
`timescale 1ns/100ps
`default_nettype none
module gee_top_tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, in_guest;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_errors = 0;
    int check_count = 0;
    gee_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .in_guest(in_guest));
    gee_monitor u_mon (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_mon.bus(1'b1, a, d, q);
    endtask : wr
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        u_mon.bus(1'b0, a, 32'h0000_0000, q);
        check_count++;
        if (q !== e) begin
            n_errors++;
            $display("wrong value reg %h expected %h seen %h", a, e, q);
        end
    endtask : ck
    ////////////////////////////////////////////////////////////////////////
    task automatic t_clear();
        // region on a 4 KB boundary
        wr(gee_pkg::A_OPLO, 32'h0000_1000);
        wr(gee_pkg::A_OPHI, 32'h0000_0000);
        // host task selector assumed zero indicator and privilege
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_CLEAR});
        ck(gee_pkg::A_STAT, 32'h0000_0000);
        ck(gee_pkg::A_WKHI, 32'hFFFF_FFFF);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_RESUME});
        ck(gee_pkg::A_STAT, 32'h0000_0001);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_LOAD});
        ck(gee_pkg::A_WKLO, 32'h0000_1000);
    endtask : t_clear
    task automatic t_badctl();
        wr(gee_pkg::A_CTRL, 32'h0000_0000);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_FIRST});
        ck(gee_pkg::A_STAT, 32'h0000_0002);
        ck(gee_pkg::A_IERR, {24'h0, gee_pkg::ERR_CTRL});
        wr(gee_pkg::A_CTRL, 32'h0000_0016);
        wr(gee_pkg::A_EINF, 32'h0000_1000);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_FIRST});
        ck(gee_pkg::A_STAT, 32'h0000_0002);
        wr(gee_pkg::A_EINF, 32'h0000_0000);
    endtask : t_badctl
    task automatic t_launch();
        wr(gee_pkg::A_CFG, 32'h0000_0001);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_FIRST});
        ck(gee_pkg::A_STAT, 32'h0000_0020);
        ck(gee_pkg::A_XRSN, gee_pkg::RSN_BADGST);
        wr(gee_pkg::A_CFG, 32'h0000_0000);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_FIRST});
        ck(gee_pkg::A_STAT, 32'h0000_000C);
        ck(gee_pkg::A_CTLO, 32'h0000_1000);
        ck(gee_pkg::A_PAHI, 32'hFFFF_FFFF);
        wr(gee_pkg::A_BMAP, 32'h0000_2000);
        wr(gee_pkg::A_GEXC, 32'h0000_000D);
        ck(gee_pkg::A_XINF, 32'h8000_030D);
        ck(gee_pkg::A_ROUT, 32'h0000_0001);
        ck(gee_pkg::A_RINF, 32'h8000_030D);
        ck(gee_pkg::A_RERR, 32'h0000_0000);
    endtask : t_launch
    // nested exit: re-enter carrying an event, fault again with vector 13
    task automatic t_nest(input logic [31:0] einf, input logic [31:0] o,
        input logic [31:0] rinf);
        // entry info bits 30:12 kept clear
        wr(gee_pkg::A_EINF, einf);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_RESUME});
        wr(gee_pkg::A_GEXC, 32'h0000_000D);
        ck(gee_pkg::A_VINF, einf);
        ck(gee_pkg::A_ROUT, o);
        ck(gee_pkg::A_RINF, rinf);
    endtask : t_nest
    task automatic t_pf();
        wr(gee_pkg::A_BMAP, 32'h0000_6000);
        wr(gee_pkg::A_FADR, 32'h1234_5000);
        wr(gee_pkg::A_CMD, {29'h0, gee_pkg::OP_RESUME});
        @(negedge hclk);
        check_count++;
        if (in_guest !== 1'b1 || hresp !== 1'b0) begin
            n_errors++;
            $display("wrong value in_guest/hresp expected 1/0 seen %b/%b",
                in_guest, hresp);
        end
        wr(gee_pkg::A_GEXC, 32'h0000_000E);
        ck(gee_pkg::A_XQUL, 32'h1234_5000);
    endtask : t_pf
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        #200us;
        n_errors++;
        stop_test();
    end
    initial begin
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ck(gee_pkg::A_CTRL, 32'h0000_0016);
        t_clear();
        t_badctl();
        t_launch();
        t_nest(32'h8000_030E, 32'h0000_0002, 32'h8000_0B08);
        t_nest(32'h8000_0301, 32'h0000_0001, 32'h8000_030D);
        t_nest(32'h8000_0308, 32'h0000_0003, 32'h0000_0000);
        t_pf();
        stop_test();
    end
endmodule : gee_top_tb_top
`default_nettype wire
